//--- rtl/serial_port_defs.vh
// Constants for the serial management port and its register bank.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Frame layout in link clock cycles, counted from 1
`define HDR_BITS        8
`define DIR_BIT_POS     1
`define ADDR_FIRST_POS  2
`define ADDR_LAST_POS   6
`define MUST_ZERO_POS   7
`define IGNORED_POS     8
`define DATA_BITS       8
`define FRAME_BITS      16
`define REG_BITS        5
`define ADDR_BITS       5

// Direction flag values
`define DIR_READ        1'b1
`define DIR_WRITE       1'b0

// Loop-back field positions within a register
`define LOCAL_LOOP_POS  1
`define REMOTE_LOOP_POS 0

// Loop-back mode encodings
`define LOOP_NONE       2'h0
`define LOOP_ANALOG     2'h1
`define LOOP_DIGITAL    2'h2
`define LOOP_REMOTE     2'h3

// Register reset value
`define REG_RESET       5'h00

// Loop-back register of channel 0; channel n sits n above it
`define LOOP_BASE_ADDR  5'h0C

`endif

//--- rtl/pin_sync.v
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the level is slow against clk_i.
`timescale 1ns/1ps
module pin_sync (
  input  wire clk_i,   // System clock
  input  wire srst_i,  // Synchronous reset, active high
  input  wire d_i,     // Asynchronous level
  output wire q_o      // Synchronised level
);
  reg meta_q;
  reg sync_q;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

//--- rtl/loop_decode.v
// Decodes one channel's loop-back select pair into a mode code.
// Assumes both selects come from registers on the same clock.
`timescale 1ns/1ps
`include "serial_port_defs.vh"
module loop_decode (
  input  wire       local_loop_sel_i,  // Local loop-back select
  input  wire       remote_loop_sel_i, // Remote loop-back select
  output reg  [1:0] mode_o             // Loop-back mode code
);
  // Four combinations map one-to-one onto modes
  always @* begin
    case ({local_loop_sel_i, remote_loop_sel_i})
      2'h0:    mode_o = `LOOP_NONE;
      2'h2:    mode_o = `LOOP_ANALOG;
      2'h3:    mode_o = `LOOP_DIGITAL;
      2'h1:    mode_o = `LOOP_REMOTE;
      default: mode_o = `LOOP_NONE;
    endcase
  end
endmodule

//--- rtl/serial_register_port.v
// Serial management port with a bank of five-bit command registers.
// Assumes the host drives the link clock, select and data; all are
// sampled by clk_i, so the link clock must be well below clk_i / 4.
// The select and serial input pass the same two-flop delay as the
// link clock, so their relation to its edges is kept. Besides srst_i,
// raising select is the only way to abandon a frame, and a write is
// committed only on its sixteenth rising edge.
`timescale 1ns/1ps
`include "serial_port_defs.vh"
module serial_register_port #(
  parameter CHANNELS  = 4, // Number of line channels
  parameter REG_COUNT = 32 // Registers behind the five-bit address
) (
  input  wire                  clk_i,             // System clock, 50 MHz
  input  wire                  srst_i,            // Sync reset, active high
  input  wire                  sel_n_i,           // Chip select, active low
  input  wire                  sclk_i,            // Host serial clock
  input  wire                  ser_in_i,          // Serial data in
  output reg                   ser_out_o,         // Serial data out
  output reg                   ser_out_oe_o,      // Serial out drive enable
  output reg  [CHANNELS-1:0]   local_loop_sel_o,  // Per-channel local select
  output reg  [CHANNELS-1:0]   remote_loop_sel_o, // Per-channel remote select
  output reg  [2*CHANNELS-1:0] loop_mode_o        // Per-channel mode codes
);
  // Loop-back register of channel n sits at this base plus n; only
  // the low two bits of each drive the loop-back outputs
  localparam [4:0] LOOP_REG_BASE = `LOOP_BASE_ADDR;

  // Frame states, one-hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_HDR  = 3'h2;
  localparam [2:0] ST_DATA = 3'h4;

  wire sel_s;
  wire sclk_s;
  wire ser_in_s;

  reg  [2:0]               state_q;
  reg  [4:0]               cyc_q;     // Rising edges seen in frame
  reg                      dir_q;
  reg  [`ADDR_BITS-1:0]    addr_q;
  reg  [`DATA_BITS-1:0]    wdata_q;
  reg  [`REG_BITS-1:0]     rdata_q;   // Read shift register
  reg                      sclk_q;
  reg  [`REG_BITS-1:0]     regs_q [0:REG_COUNT-1];
  wire [2*CHANNELS-1:0]    mode_w;
  wire                     rise_w;
  wire                     fall_w;
  integer                  i;
  integer                  k;

  // Next values of the frame, read and loop-back select registers
  reg  [2:0]               state_d;
  reg  [4:0]               cyc_d;
  reg                      dir_d;
  reg  [`ADDR_BITS-1:0]    addr_d;
  reg  [`DATA_BITS-1:0]    wdata_d;
  reg  [`REG_BITS-1:0]     rdata_d;
  reg                      ser_out_d;
  reg                      ser_out_oe_d;
  reg  [CHANNELS-1:0]      local_loop_d;
  reg  [CHANNELS-1:0]      remote_loop_d;

  // Frame slot decode; the strobes last one clk_i cycle at most
  wire                     in_frame_w;  // Select low, synchronised
  wire                     is_read_w;   // Frame carries a read
  wire                     dir_slot_w;  // Rise carries the direction flag
  wire                     addr_slot_w; // Rise carries an address bit
  wire                     hdr_end_w;   // Rise carries header bit eight
  wire                     data_slot_w; // Rise carries a data bit
  wire                     commit_w;    // Rise carries write bit D7
  wire                     launch_w;    // Fall that puts out read bit D0
  wire                     shift_w;     // Fall that moves the read shifter
  wire                     stop_w;      // Fall that ends the read drive
  wire [`REG_BITS-1:0]     sel_reg_w;   // Register named by the address

  // Every pin crosses two flip-flops before the logic sees it
  // Select enters inverted, so the synchroniser's reset level means
  // deselected and no frame seems to start as reset ends
  pin_sync u_sync_sel (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (~sel_n_i),
    .q_o    (sel_s)
  );
  pin_sync u_sync_clk (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (sclk_i),
    .q_o    (sclk_s)
  );
  pin_sync u_sync_din (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (ser_in_i),
    .q_o    (ser_in_s)
  );

  // Edge detection on the synchronised link clock
  always @(posedge clk_i) begin
    if (srst_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  assign rise_w = sclk_s & ~sclk_q;
  assign fall_w = ~sclk_s & sclk_q;

  // Slot decode from the rising-edge count. One count serves the
  // sequencer, the bank and the read side, so no field can drift
  // against another when the frame layout is touched.
  assign in_frame_w  = sel_s;
  assign is_read_w   = (dir_q == `DIR_READ);
  assign dir_slot_w  = (state_q == ST_HDR) && rise_w &&
                       (cyc_q == `DIR_BIT_POS - 1);
  assign addr_slot_w = (state_q == ST_HDR) && rise_w &&
                       (cyc_q >= `ADDR_FIRST_POS - 1) &&
                       (cyc_q <= `ADDR_LAST_POS - 1);
  assign hdr_end_w   = (state_q == ST_HDR) && rise_w &&
                       (cyc_q == `IGNORED_POS - 1);
  assign data_slot_w = (state_q == ST_DATA) && rise_w &&
                       (cyc_q < `FRAME_BITS);
  assign commit_w    = data_slot_w && !is_read_w &&
                       (cyc_q == `FRAME_BITS - 1);
  // Read side moves on falling edges only, half a link period
  // before the host samples on the next rise
  assign launch_w    = (state_q == ST_DATA) && is_read_w && fall_w &&
                       (cyc_q == `HDR_BITS);
  assign shift_w     = (state_q == ST_DATA) && is_read_w && fall_w &&
                       (cyc_q > `HDR_BITS) && (cyc_q < `FRAME_BITS);
  assign stop_w      = (state_q == ST_DATA) && is_read_w && fall_w &&
                       (cyc_q >= `FRAME_BITS);
  assign sel_reg_w   = regs_q[addr_q];

  // Sequencer next state; select high drops the frame at once
  always @* begin
    // Defaults hold every register between slots
    state_d = state_q;
    cyc_d   = cyc_q;
    dir_d   = dir_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    if (!in_frame_w) begin
      state_d = ST_IDLE;
      cyc_d   = 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_HDR;
          cyc_d   = 5'h00;
        end
        ST_HDR: begin
          if (rise_w) begin
            cyc_d = cyc_q + 5'h01;
          end
          if (dir_slot_w) begin
            dir_d = ser_in_s;
          end
          if (addr_slot_w) begin
            // LSB arrives first, so shift in from the top
            addr_d = {ser_in_s, addr_q[`ADDR_BITS-1:1]};
          end
          // Bits seven and eight are counted but never stored
          if (hdr_end_w) begin
            state_d = ST_DATA;
          end
        end
        ST_DATA: begin
          // Edges after the sixteenth are ignored until select rises
          if (data_slot_w) begin
            cyc_d   = cyc_q + 5'h01;
            wdata_d = {ser_in_s, wdata_q[`DATA_BITS-1:1]};
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      cyc_q   <= 5'h00;
      dir_q   <= `DIR_WRITE;
      addr_q  <= {`ADDR_BITS{1'b0}};
      wdata_q <= {`DATA_BITS{1'b0}};
    end else begin
      state_q <= state_d;
      cyc_q   <= cyc_d;
      dir_q   <= dir_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  // Register bank; a write commits on the sixteenth rising edge only,
  // so a frame cut short by select leaves its target untouched
  always @(posedge clk_i) begin
    if (srst_i) begin
      for (i = 0; i < REG_COUNT; i = i + 1) begin
        regs_q[i] <= `REG_RESET;
      end
    end else if (commit_w && in_frame_w) begin
      // D0 to D4 sit in bits 1 to 5 by now; D5 to D7 fall away
      regs_q[addr_q] <= wdata_q[`REG_BITS:1];
    end
  end

  // Read launch and shift; D0 leaves on the fall after rise eight,
  // then D1 to D4, then the zeros shifted in behind them
  always @* begin
    // Defaults hold the pin and the shifter between falls
    ser_out_d    = ser_out_o;
    ser_out_oe_d = ser_out_oe_o;
    rdata_d      = rdata_q;
    if (!in_frame_w || state_q != ST_DATA || !is_read_w) begin
      ser_out_d    = 1'b0;
      ser_out_oe_d = 1'b0;
    end else if (launch_w) begin
      ser_out_oe_d = 1'b1;
      ser_out_d    = sel_reg_w[0];
      rdata_d      = {1'b0, sel_reg_w[`REG_BITS-1:1]};
    end else if (shift_w) begin
      // Zeros shifted in give the three trailing zero bits
      ser_out_d = rdata_q[0];
      rdata_d   = {1'b0, rdata_q[`REG_BITS-1:1]};
    end else if (stop_w) begin
      ser_out_d    = 1'b0;
      ser_out_oe_d = 1'b0;
    end
  end

  // Serial out registers, so the pin comes straight from flip-flops
  always @(posedge clk_i) begin
    if (srst_i) begin
      ser_out_o    <= 1'b0;
      ser_out_oe_o <= 1'b0;
      rdata_q      <= {`REG_BITS{1'b0}};
    end else begin
      ser_out_o    <= ser_out_d;
      ser_out_oe_o <= ser_out_oe_d;
      rdata_q      <= rdata_d;
    end
  end

  // Gather each channel's pair out of its loop-back register; the
  // other three bits of that register are stored but not used here
  always @* begin
    local_loop_d  = {CHANNELS{1'b0}};
    remote_loop_d = {CHANNELS{1'b0}};
    for (k = 0; k < CHANNELS; k = k + 1) begin
      local_loop_d[k]  = regs_q[LOOP_REG_BASE + k][`LOCAL_LOOP_POS];
      remote_loop_d[k] = regs_q[LOOP_REG_BASE + k][`REMOTE_LOOP_POS];
    end
  end

  // Loop-back decode per channel, one small decoder each, fed from
  // the same gathered pairs as the select outputs
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      loop_decode u_dec (
        .local_loop_sel_i  (local_loop_d[g]),
        .remote_loop_sel_i (remote_loop_d[g]),
        .mode_o            (mode_w[2*g+1:2*g])
      );
    end
  endgenerate

  // Loop-back outputs registered so they come from flip-flops; the
  // selects and the mode code change on the same clk_i edge
  always @(posedge clk_i) begin
    if (srst_i) begin
      local_loop_sel_o  <= {CHANNELS{1'b0}};
      remote_loop_sel_o <= {CHANNELS{1'b0}};
      loop_mode_o       <= {2*CHANNELS{1'b0}};
    end else begin
      local_loop_sel_o  <= local_loop_d;
      remote_loop_sel_o <= remote_loop_d;
      loop_mode_o       <= mode_w;
    end
  end
endmodule

//--- testbench/serial_port_chk.sv
// Checker for the serial register port, attached by bind.
// Assumes the link clock runs at exactly clk_i / 8.
`timescale 1ns/1ps
module serial_port_chk #(
  parameter CHANNELS = 4
) (
  input wire                  clk_i,             // Clock
  input wire                  srst_i,            // Reset
  input wire                  sel_n_i,           // Select, low
  input wire                  sclk_i,            // Link clock
  input wire                  ser_in_i,          // Data in
  input wire                  ser_out_o,         // Data out
  input wire                  ser_out_oe_o,      // Out enable
  input wire [CHANNELS-1:0]   local_loop_sel_o,  // Local
  input wire [CHANNELS-1:0]   remote_loop_sel_o, // Remote
  input wire [2*CHANNELS-1:0] loop_mode_o        // Modes
);
  reg [7:0]            oe_len_q;
  reg [2*CHANNELS-1:0] mode_x;
  integer              n;
  // Expected codes, remote bit high, low bit is the pair's parity
  always @* begin
    for (n = 0; n < CHANNELS; n = n + 1)
      mode_x[2*n+:2] = {remote_loop_sel_o[n],
                        local_loop_sel_o[n] ^ remote_loop_sel_o[n]};
  end
  // Cycles the output has been driven; saturates
  always @(posedge clk_i) begin
    if (srst_i || !ser_out_oe_o)
      oe_len_q <= 8'h00;
    else if (oe_len_q != 8'hFF)
      oe_len_q <= oe_len_q + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sel_off_a: assert property (sel_n_i [*5] |-> !ser_out_oe_o)
    else $error("out driven while deselected");
  mode_dec_a: assert property ($stable(local_loop_sel_o) &&
    $stable(remote_loop_sel_o) |-> loop_mode_o == mode_x)
    else $error("loop mode code wrong");
  oe_rise_sel_a: assert property ($rose(ser_out_oe_o) |-> !sel_n_i)
    else $error("out enabled outside frame");
  oe_rise_low_a: assert property ($rose(ser_out_oe_o) |->
    !sclk_i && !$past(sclk_i, 2)) else $error("enable not on fall");
  shift_low_a: assert property (ser_out_oe_o && $past(ser_out_oe_o) &&
    $changed(ser_out_o) |-> !sclk_i) else $error("out moved on rise");
  oe_len_max_a: assert property (ser_out_oe_o |-> oe_len_q < 8'h42)
    else $error("out held too long");
  oe_len_min_a: assert property ($fell(ser_out_oe_o) && !sel_n_i |->
    oe_len_q > 8'h3D) else $error("out released early");
  loop_hold_a: assert property ($changed(local_loop_sel_o) ||
    $changed(remote_loop_sel_o) |-> !$past(sel_n_i, 4))
    else $error("selects moved outside frame");
endmodule
bind serial_register_port serial_port_chk #(.CHANNELS(CHANNELS)) chk (
  .clk_i(clk_i), .srst_i(srst_i), .sel_n_i(sel_n_i), .sclk_i(sclk_i),
  .ser_in_i(ser_in_i), .ser_out_o(ser_out_o),
  .ser_out_oe_o(ser_out_oe_o), .local_loop_sel_o(local_loop_sel_o),
  .remote_loop_sel_o(remote_loop_sel_o), .loop_mode_o(loop_mode_o));

//--- testbench/host_port_model.sv
// Host model that runs frames on the serial port.
// Assumes clk_i is the bench clock; drives on its falling edge.
`timescale 1ns/1ps
module host_port_model (
  input  wire clk_i,            // Bench clock
  input  wire ser_out_i,        // Device data out
  input  wire oe_i,             // Device drive enable
  output reg  sel_n_o = 1'b1,   // Chip select, low
  output reg  sclk_o = 1'b0,    // Link clock, 160 ns
  output reg  ser_in_o = 1'b0   // Data to device
);
  // One frame of nb bits; q holds read bits, bad flags a stray drive
  task automatic frame(input rd, input [4:0] a, input [7:0] wd,
                       input integer nb, output [7:0] q, output bad);
    reg [15:0] b;
    integer    i;
    b = {wd, 1'($urandom), 1'b0, a, rd};
    q = 8'h00;
    bad = 1'b0;
    sclk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b0;
    sel_n_o = 1'b0;
    for (i = 0; i < nb; i = i + 1) begin
      ser_in_o = (rd && i > 7) ? 1'($urandom) : b[i];
      repeat (4) @(negedge clk_i);
      if (i > 7) q[i-8] = oe_i ? ser_out_i : 1'bx;
      if (oe_i && !(rd && i > 7)) bad = 1'b1;
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (6) @(negedge clk_i);
    sel_n_o = 1'b1;
    ser_in_o = ~ser_in_o; // Released line, no stale level
    repeat (8) @(negedge clk_i);
  endtask
endmodule

//--- testbench/serial_register_port_bench.sv
// Self-checking bench for the serial register port.
// Assumes host_port_model drives the port pins.
`timescale 1ns/1ps
module serial_register_port_bench;
  reg        clk = 1'b0;
  reg        srst = 1'b1;
  wire       sel_n, sclk, sin, sout, soe;
  wire [3:0] lsel, rsel;
  wire [7:0] mode;
  reg  [4:0] mem [0:31];
  reg  [7:0] q;
  reg        bad;
  integer    err_total = 0, num_checks = 0, i, m;
  initial forever #10 clk = ~clk;
  serial_register_port uut (.clk_i(clk), .srst_i(srst), .sel_n_i(sel_n),
    .sclk_i(sclk), .ser_in_i(sin), .ser_out_o(sout), .ser_out_oe_o(soe),
    .local_loop_sel_o(lsel), .remote_loop_sel_o(rsel), .loop_mode_o(mode));
  host_port_model host (.clk_i(clk), .ser_out_i(sout), .oe_i(soe),
    .sel_n_o(sel_n), .sclk_o(sclk), .ser_in_o(sin));
  task cmp(input string what, input [7:0] e, input [7:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("[FAIL] %0s expected %h seen %h", what, e, g);
    end
  endtask
  function [1:0] dec(input [1:0] lr);
    dec = lr[1] ? (lr[0] ? 2'h2 : 2'h1) : (lr[0] ? 2'h3 : 2'h0);
  endfunction
  // Loop outputs against the model of registers 0x0C to 0x0F
  task chk_loops;
    for (m = 0; m < 4; m = m + 1)
      cmp("loops", {4'h0, dec(mem[12+m][1:0]), mem[12+m][1:0]},
          {4'h0, mode[2*m+:2], lsel[m], rsel[m]});
  endtask
  task wr(input [4:0] a, input [7:0] d, input integer nb);
    host.frame(1'b0, a, d, nb, q, bad);
    cmp("oe", 8'h00, {7'h00, bad});
    if (nb == 16) mem[a] = d[4:0];
  endtask
  task rd(input [4:0] a);
    host.frame(1'b1, a, 8'h00, 16, q, bad);
    cmp("oe", 8'h00, {7'h00, bad});
    cmp("rdata", {3'h0, mem[a]}, q);
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog, nearly three times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    i = $urandom(16);
    for (i = 0; i < 32; i = i + 1) mem[i] = 5'h00;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    rd(5'h0F);
    // Every channel through every mode, upper bits random
    for (i = 0; i < 16; i = i + 1) begin
      wr({3'h3, i[1:0]}, {6'($urandom), i[3:2]}, 16);
      chk_loops;
    end
    for (i = 0; i < 4; i = i + 1) rd({3'h3, i[1:0]});
    repeat (24) begin
      if ($urandom % 2) wr(5'($urandom), 8'($urandom), 16);
      else rd(5'($urandom));
    end
    // Cut-short write must leave the register alone
    wr(5'h0D, 8'h1F, 1 + $urandom % 15);
    rd(5'h0D);
    chk_loops;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (i = 0; i < 32; i = i + 1) mem[i] = 5'h00;
    repeat (6) @(negedge clk);
    rd(5'h0E);
    chk_loops;
    summarize;
  end
endmodule
